// file: common/sat_cfg_pkg.sv
// Functional notes
// - Four independent channel configuration registers.
// - Bit 13 one flushes that channel's FIFO.
// - Bit 12 zero writes bits 13,12,9..0.
// - Bit 12 one writes bits 13..10,5,4.
// - Bits 11..10 select the reply mode.
// - Bits 9..8 select the bit-time range.
// - Bits 7..6 apply only in B protocol.
// - Bit 3 enables threshold hysteresis.
// - Bits 2..0 pick one of eight thresholds.
// - Satellite current passes a deglitch filter.
// - Bits 5..4 control supply and decoder.
// - B field length codes give 8..11 bits.
// - Bit-time codes give four frequency ranges.
// - Reply modes: echo, master, channel, FIFO.
// - Flush discards both FIFO locations.
//
// Purpose: Constants shared by the channel configuration bank and its filter.
// Assumes: 20 MHz system clock; word framing done upstream.
// Notes:   Field positions are bit indices inside the 14-bit register.
`default_nettype none

package sat_cfg_pkg;

  // ==========================================================================
  // Geometry
  localparam int NUM_CH = 4;
  localparam int CFG_W = 14;
  localparam int WORD_W = 16;
  localparam int CH_IDX_W = 2;

  // ==========================================================================
  // Field positions
  localparam int FLUSH_BIT = 13;
  localparam int WMODE_BIT = 12;
  localparam int REPLY_LSB = 10;
  localparam int BTIME_LSB = 8;
  localparam int BLEN_LSB = 6;
  localparam int SUPPLY_LSB = 4;
  localparam int HYST_BIT = 3;
  localparam int THR_LSB = 0;
  localparam int THR_W = 3;

  // ==========================================================================
  // Write masks and reset value
  localparam logic [CFG_W-1:0] MASK_LOW = 14'h33ff;
  localparam logic [CFG_W-1:0] MASK_HIGH = 14'h3c30;
  localparam logic [CFG_W-1:0] CFG_RESET = 14'h0000;

  // ==========================================================================
  // Codes
  localparam logic [1:0] REPLY_ECHO = 2'h0;
  localparam logic [1:0] REPLY_MASTER = 2'h1;
  localparam logic [1:0] REPLY_CHANNEL = 2'h2;
  localparam logic [1:0] REPLY_FIFO = 2'h3;
  localparam logic [1:0] BLEN_8 = 2'h0;
  localparam logic [1:0] BTIME_SLOW = 2'h0;
  localparam logic [1:0] SUP_BOTH_OFF = 2'h0;
  localparam logic [1:0] SUP_SAT_ONLY = 2'h1;
  localparam logic [1:0] SUP_BOTH_ON = 2'h2;

  // ==========================================================================
  // Timing
  localparam int CLK_NS = 50;
  localparam int DEGLITCH_NS = 200;
  localparam int DEGLITCH_CYC = (DEGLITCH_NS + CLK_NS - 1) / CLK_NS;

endpackage : sat_cfg_pkg

`default_nettype wire

// file: common/deglitch_if.sv
// Purpose: Carries raw and filtered comparator levels between bank and filter.
// Assumes: One bit per satellite channel.
// Notes:   No clocking block; plain levels only.
`default_nettype none

interface deglitch_if #(
  parameter int N = 4
);
  logic [N-1:0] raw;
  logic [N-1:0] clean;

  modport filt (input raw, output clean);
  modport user (output raw, input clean);
endinterface : deglitch_if

`default_nettype wire

// file: logic/level_deglitch.sv
// Purpose: Per-channel deglitch of the satellite current comparator level.
// Assumes: Raw level synchronous to clk.
// Notes:   A level change passes only after it has held for CYCLES clocks.
`default_nettype none

module level_deglitch #(
  parameter int N = 4,
  parameter int CYCLES = 4
) (
  // Clock and synchronised reset
  input wire logic clk,
  input wire logic rst_n,
  // Levels
  deglitch_if.filt lv
);
  import sat_cfg_pkg::*;

  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  if (CYCLES < 1) begin : g_chk
    $error("level_deglitch: CYCLES must be at least one");
  end

  typedef struct packed {
    logic [N-1:0][CW-1:0] cnt;
    logic [N-1:0] clean;
  } dg_state_t;

  dg_state_t st_r;
  dg_state_t st_nxt;

  // ==========================================================================
  // Filter
  always_comb begin
    st_nxt = st_r;
    for (int i = 0; i < N; i++) begin
      if (lv.raw[i] == st_r.clean[i]) begin
        st_nxt.cnt[i] = '0;
      end else if (st_r.cnt[i] == LAST) begin
        st_nxt.clean[i] = lv.raw[i];
        st_nxt.cnt[i] = '0;
      end else begin
        st_nxt.cnt[i] = st_r.cnt[i] + CW'(1);
      end
    end
    if (!rst_n) begin
      st_nxt = '0;
    end
  end

  always_ff @(posedge clk) begin
    st_r <= st_nxt;
  end

  assign lv.clean = st_r.clean;

endmodule : level_deglitch

`default_nettype wire

// file: logic/channel_config_bank.sv
// Purpose: Four channel configuration registers for the satellite interface.
// Assumes: Words arrive already framed, one strobe per channel word.
// Notes:   Decoded controls and readback are all registered.
`default_nettype none

module channel_config_bank #(
  parameter int DEGLITCH_CYCLES = sat_cfg_pkg::DEGLITCH_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Channel word write port
  input wire logic wr_en,
  input wire logic [sat_cfg_pkg::CH_IDX_W-1:0] wr_chan,
  input wire logic [sat_cfg_pkg::WORD_W-1:0] wr_word,
  // Master configuration protocol selection, one bit per channel, 1 = B
  input wire logic [sat_cfg_pkg::NUM_CH-1:0] proto_b,
  // Register readback
  input wire logic [sat_cfg_pkg::CH_IDX_W-1:0] rd_chan,
  output logic [sat_cfg_pkg::CFG_W-1:0] rd_data,
  // Per-channel controls
  output logic [sat_cfg_pkg::NUM_CH-1:0] fifo_flush,
  output logic [sat_cfg_pkg::NUM_CH-1:0][1:0] reply_mode,
  output logic [sat_cfg_pkg::NUM_CH-1:0][1:0] bit_time_sel,
  output logic [sat_cfg_pkg::NUM_CH-1:0][1:0] b_field_len,
  output logic [sat_cfg_pkg::NUM_CH-1:0] sat_supply_on,
  output logic [sat_cfg_pkg::NUM_CH-1:0] decoder_on,
  output logic [sat_cfg_pkg::NUM_CH-1:0] hyst_en,
  output logic [sat_cfg_pkg::NUM_CH-1:0][sat_cfg_pkg::THR_W-1:0] thr_sel,
  // Current comparator levels
  input wire logic [sat_cfg_pkg::NUM_CH-1:0] cur_raw,
  output logic [sat_cfg_pkg::NUM_CH-1:0] cur_to_decoder
);
  import sat_cfg_pkg::*;

  if (DEGLITCH_CYCLES < 1) begin : g_chk
    $error("channel_config_bank: DEGLITCH_CYCLES must be at least one");
  end

  // ==========================================================================
  // State
  typedef struct packed {
    logic [1:0] rst_sync;
    logic [NUM_CH-1:0][CFG_W-1:0] cfg;
    logic [NUM_CH-1:0] flush;
    logic [NUM_CH-1:0] sat_on;
    logic [NUM_CH-1:0] dec_on;
    logic [NUM_CH-1:0][1:0] blen;
    logic [NUM_CH-1:0] to_dec;
    logic [CFG_W-1:0] rd;
  } bank_state_t;

  bank_state_t st_r;
  bank_state_t st_nxt;

  // ==========================================================================
  // Helpers
  function automatic logic [CFG_W-1:0] merge_word(
    input logic [CFG_W-1:0] old_v,
    input logic [CFG_W-1:0] new_v
  );
    logic [CFG_W-1:0] m;
    m = MASK_LOW;
    if (new_v[WMODE_BIT]) begin
      m = MASK_HIGH;
    end
    merge_word = (old_v & ~m) | (new_v & m);
  endfunction : merge_word

  // Returns {satellite on, decoder on}.
  function automatic logic [1:0] supply_decode(input logic [1:0] code);
    logic [1:0] r;
    r = 2'h0;
    case (code)
      SUP_SAT_ONLY: r = 2'h2;
      SUP_BOTH_ON: r = 2'h3;
      default: r = 2'h0;
    endcase
    supply_decode = r;
  endfunction : supply_decode

  // ==========================================================================
  // Deglitch filter
  deglitch_if #(.N(NUM_CH)) dg ();

  assign dg.raw = cur_raw;

  level_deglitch #(
    .N(NUM_CH),
    .CYCLES(DEGLITCH_CYCLES)
  ) u_deglitch (
    .clk(clk),
    .rst_n(st_r.rst_sync[1]),
    .lv(dg)
  );

  // ==========================================================================
  // Next state
  always_comb begin
    logic [1:0] sd;
    logic [CFG_W-1:0] word;
    sd = 2'h0;
    word = wr_word[CFG_W-1:0];
    st_nxt = st_r;
    st_nxt.rst_sync = {st_r.rst_sync[0], 1'b1};
    st_nxt.flush = '0;
    for (int i = 0; i < NUM_CH; i++) begin
      // Flush is a command, not a setting, so it never stays set.
      st_nxt.cfg[i][FLUSH_BIT] = 1'b0;
      if (wr_en && (wr_chan == CH_IDX_W'(i))) begin
        st_nxt.cfg[i] = merge_word(st_r.cfg[i], word);
        st_nxt.cfg[i][FLUSH_BIT] = 1'b0;
        st_nxt.flush[i] = word[FLUSH_BIT];
      end
      sd = supply_decode(st_r.cfg[i][SUPPLY_LSB +: 2]);
      st_nxt.sat_on[i] = sd[1];
      st_nxt.dec_on[i] = sd[0];
      // B length only in B protocol.
      st_nxt.blen[i] = proto_b[i] ? st_r.cfg[i][BLEN_LSB +: 2] : BLEN_8;
      st_nxt.to_dec[i] = dg.clean[i] & st_r.dec_on[i];
    end
    st_nxt.rd = st_r.cfg[rd_chan];
    if (!st_r.rst_sync[1]) begin
      st_nxt.cfg = {NUM_CH{CFG_RESET}};
      st_nxt.flush = '0;
      st_nxt.sat_on = '0;
      st_nxt.dec_on = '0;
      st_nxt.blen = '0;
      st_nxt.to_dec = '0;
      st_nxt.rd = '0;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================================
  // Outputs
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      reply_mode[i] = st_r.cfg[i][REPLY_LSB +: 2];
      bit_time_sel[i] = st_r.cfg[i][BTIME_LSB +: 2];
      hyst_en[i] = st_r.cfg[i][HYST_BIT];
      thr_sel[i] = st_r.cfg[i][THR_LSB +: THR_W];
    end
  end

  assign rd_data = st_r.rd;
  assign fifo_flush = st_r.flush;
  assign b_field_len = st_r.blen;
  assign sat_supply_on = st_r.sat_on;
  assign decoder_on = st_r.dec_on;
  assign cur_to_decoder = st_r.to_dec;

endmodule : channel_config_bank

`default_nettype wire

// file: verif/channel_config_bank_asserts.sv
// Purpose: Port checks for the channel configuration bank.
// Assumes: One clock; checks sleep while resetn is low.
// Notes:   Deglitch checks use channel 0 only.
`default_nettype none

module channel_config_bank_asserts
  import sat_cfg_pkg::*;
#(
  parameter int DEGLITCH_CYCLES = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Write and readback
  input wire logic wr_en,
  input wire logic [sat_cfg_pkg::CH_IDX_W-1:0] wr_chan,
  input wire logic [sat_cfg_pkg::WORD_W-1:0] wr_word,
  input wire logic [sat_cfg_pkg::NUM_CH-1:0] proto_b,
  input wire logic [sat_cfg_pkg::CH_IDX_W-1:0] rd_chan,
  input wire logic [sat_cfg_pkg::CFG_W-1:0] rd_data,
  // Controls
  input wire logic [sat_cfg_pkg::NUM_CH-1:0] fifo_flush,
  input wire logic [sat_cfg_pkg::NUM_CH-1:0][1:0] reply_mode,
  input wire logic [sat_cfg_pkg::NUM_CH-1:0][1:0] b_field_len,
  input wire logic [sat_cfg_pkg::NUM_CH-1:0] sat_supply_on,
  input wire logic [sat_cfg_pkg::NUM_CH-1:0] decoder_on,
  input wire logic [sat_cfg_pkg::NUM_CH-1:0] cur_raw,
  input wire logic [sat_cfg_pkg::NUM_CH-1:0] cur_to_decoder
);
  // The held-level check below allows at most six filter clocks.
  if (DEGLITCH_CYCLES > 6) begin : g_chk
    $error("channel_config_bank_asserts: DEGLITCH_CYCLES too long for p_pass");
  end
  // ======
  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  property p_flush;
    wr_en && wr_word[FLUSH_BIT] |=> fifo_flush[$past(wr_chan)];
  endproperty
  a_flush: assert property (p_flush) else $error("flush pulse missing");
  property p_quiet;
    !(wr_en && wr_word[FLUSH_BIT]) |=> fifo_flush == 4'h0;
  endproperty
  a_quiet: assert property (p_quiet) else $error("stray flush pulse");
  property p_echo;
    wr_en && !wr_word[WMODE_BIT] && wr_chan == rd_chan ##1 $stable(rd_chan)
      |=> rd_data[9:0] == $past(wr_word[9:0], 2);
  endproperty
  a_echo: assert property (p_echo) else $error("low field write lost");
  property p_mode_hi;
    wr_en && wr_word[WMODE_BIT] |=> reply_mode[$past(wr_chan)] == $past(wr_word[11:10]);
  endproperty
  a_mode_hi: assert property (p_mode_hi) else $error("reply mode not written");
  property p_mode_lo;
    wr_en && !wr_word[WMODE_BIT] |=> reply_mode[$past(wr_chan)] == $past(reply_mode[wr_chan]);
  endproperty
  a_mode_lo: assert property (p_mode_lo) else $error("reply mode changed");
  property p_blen;
    !proto_b[3] [*2] |-> b_field_len[3] == 2'h0;
  endproperty
  a_blen: assert property (p_blen) else $error("B length in A protocol");
  property p_dec;
    (decoder_on & ~sat_supply_on) == 4'h0;
  endproperty
  a_dec: assert property (p_dec) else $error("decoder on without supply");
  property p_pass;
    (decoder_on[0] && cur_raw[0]) [*8] |-> cur_to_decoder[0];
  endproperty
  a_pass: assert property (p_pass) else $error("held level not passed");
endmodule : channel_config_bank_asserts

bind channel_config_bank channel_config_bank_asserts #(
  .DEGLITCH_CYCLES(DEGLITCH_CYCLES)
) chk_u (
  .clk(clk),
  .resetn(resetn),
  .wr_en(wr_en),
  .wr_chan(wr_chan),
  .wr_word(wr_word),
  .proto_b(proto_b),
  .rd_chan(rd_chan),
  .rd_data(rd_data),
  .fifo_flush(fifo_flush),
  .reply_mode(reply_mode),
  .b_field_len(b_field_len),
  .sat_supply_on(sat_supply_on),
  .decoder_on(decoder_on),
  .cur_raw(cur_raw),
  .cur_to_decoder(cur_to_decoder)
);

`default_nettype wire

// file: verif/host_model.sv
// Purpose: Host side of the channel word link, one framed word per call.
// Assumes: Called only after the bank's reset sync has settled.
// Notes:   Idle word lines carry the inverse of the last word.
`default_nettype none

module host_model
  import sat_cfg_pkg::*;
(
  // Clock
  input wire logic clk,
  // Write port
  output logic wr_en,
  output logic [sat_cfg_pkg::CH_IDX_W-1:0] wr_chan,
  output logic [sat_cfg_pkg::WORD_W-1:0] wr_word
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    wr_en = 1'b0;
    wr_chan = 2'h0;
    wr_word = 16'h0000;
  end
  // ======
  // Word transfer
  task automatic send(input logic [1:0] ch, input logic [15:0] w);
    @(negedge clk);
    wr_en = 1'b1;
    wr_chan = ch;
    wr_word = w;
    @(negedge clk);
    wr_en = 1'b0;
    wr_word = ~w;
  endtask : send
endmodule : host_model

`default_nettype wire

// file: verif/satellite_channel_config_bench.sv
// Purpose: Self-checking bench for the channel configuration bank.
// Assumes: 50 ns clock; the host model drives the write port.
// Notes:   Deglitch span cut to 2 clocks to keep the run short.
`default_nettype none

module satellite_channel_config_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import sat_cfg_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic wr_en;
  logic [1:0] wr_chan, rd_chan = 2'h0;
  logic [15:0] wr_word;
  logic [3:0] proto_b = 4'h0, cur_raw = 4'h0;
  logic [13:0] rd_data;
  logic [3:0][1:0] reply_mode, bit_time_sel, b_field_len;
  logic [3:0] fifo_flush, sat_supply_on, decoder_on, hyst_en, cur_to_decoder;
  logic [3:0][2:0] thr_sel;
  int mismatches = 0;
  int n_tests = 0;
  always #25 clk = ~clk;
  host_model host_u (.clk(clk), .wr_en(wr_en), .wr_chan(wr_chan), .wr_word(wr_word));
  channel_config_bank #(.DEGLITCH_CYCLES(2)) dut_u (
    .clk(clk),
    .resetn(resetn),
    .wr_en(wr_en),
    .wr_chan(wr_chan),
    .wr_word(wr_word),
    .proto_b(proto_b),
    .rd_chan(rd_chan),
    .rd_data(rd_data),
    .fifo_flush(fifo_flush),
    .reply_mode(reply_mode),
    .bit_time_sel(bit_time_sel),
    .b_field_len(b_field_len),
    .sat_supply_on(sat_supply_on),
    .decoder_on(decoder_on),
    .hyst_en(hyst_en),
    .thr_sel(thr_sel),
    .cur_raw(cur_raw),
    .cur_to_decoder(cur_to_decoder)
  );
  // ======
  // Helpers
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic rd_chk(input logic [1:0] c, input logic [13:0] e);
    rd_chan = c;
    @(negedge clk);
    chk({2'h0, rd_data}, {2'h0, e});
  endtask : rd_chk
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : report_and_stop
  // ======
  // Scenarios
  task automatic t_reset();
    for (int c = 0; c < 4; c++) begin
      rd_chk(c[1:0], CFG_RESET);
    end
    chk({4'h0, sat_supply_on, decoder_on, fifo_flush}, 16'h0000);
  endtask : t_reset
  task automatic t_masks();
    host_u.send(2'h1, 16'hc3ff);
    rd_chk(2'h1, 14'h03ff);
    chk({8'h00, thr_sel[1], hyst_en[1], bit_time_sel[1], reply_mode[1]}, 16'h00fc);
    host_u.send(2'h1, 16'h1800);
    rd_chk(2'h1, 14'h1bcf);
    host_u.send(2'h1, 16'h0000);
    rd_chk(2'h1, 14'h0800);
    chk({14'h0000, reply_mode[1]}, 16'h0002);
  endtask : t_masks
  task automatic t_flush();
    host_u.send(2'h2, 16'h2000);
    chk({12'h000, fifo_flush}, 16'h0004);
    @(negedge clk);
    chk({12'h000, fifo_flush}, 16'h0000);
    rd_chk(2'h2, 14'h0000);
    rd_chk(2'h1, 14'h0800);
  endtask : t_flush
  task automatic t_power();
    logic [1:0] tbl [4] = '{2'h0, 2'h2, 2'h3, 2'h0};
    for (int k = 0; k < 4; k++) begin
      host_u.send(2'h0, {10'h040, k[1:0], 4'h0});
      @(negedge clk);
      chk({14'h0000, sat_supply_on[0], decoder_on[0]}, {14'h0000, tbl[k]});
    end
  endtask : t_power
  task automatic t_blen();
    for (int k = 0; k < 4; k++) begin
      proto_b = 4'h0;
      host_u.send(2'h3, {8'h00, k[1:0], 6'h00});
      @(negedge clk);
      chk({14'h0000, b_field_len[3]}, 16'h0000);
      proto_b = 4'h8;
      repeat (2) @(negedge clk);
      chk({14'h0000, b_field_len[3]}, {14'h0000, k[1:0]});
    end
  endtask : t_blen
  task automatic t_deglitch();
    host_u.send(2'h0, 16'h1020);
    cur_raw = 4'h1;
    @(negedge clk);
    cur_raw = 4'h0;
    repeat (6) begin
      @(negedge clk);
      chk({15'h0000, cur_to_decoder[0]}, 16'h0000);
    end
    cur_raw = 4'h1;
    repeat (10) @(negedge clk);
    chk({15'h0000, cur_to_decoder[0]}, 16'h0001);
  endtask : t_deglitch
  task automatic t_midreset();
    resetn = 1'b0;
    @(negedge clk);
    chk({cur_to_decoder, sat_supply_on, decoder_on, fifo_flush}, 16'h0000);
    resetn = 1'b1;
    repeat (4) @(negedge clk);
    t_reset();
    chk({12'h000, cur_to_decoder}, 16'h0000);
  endtask : t_midreset
  initial begin
    repeat (5) @(negedge clk);
    resetn = 1'b1;
    repeat (4) @(negedge clk);
    t_reset();
    t_masks();
    t_flush();
    t_power();
    t_blen();
    t_deglitch();
    t_midreset();
    report_and_stop();
  end
  initial begin
    #(50 * 2000);
    mismatches++;
    report_and_stop();
  end
endmodule : satellite_channel_config_bench

`default_nettype wire
